// ==== inc/ssq_map.svh ====
// Register offsets, reset values and timing counts of the sequencer
//
// Function
// - After acquisition is complete a low start input begins a conversion.
// - A conversion first opens the ground switches, then puts the arrays on reference ground.
// - The held sample is resolved by 16 binary-weighted trials, most significant first.
// - After the last trial the code is formed and busy then goes low.
// - The fast mode allows up to 1 MSPS.
// - Normal mode allows up to 800 kSPS with no limit on the gap between conversions.
// - Low-power mode saves power between conversions and is limited to 666 kSPS.
// - The coding-select input chooses straight binary or two's complement output.
// - Two's complement codes top out at 0111...1 and the sign bit marks negative inputs.
// - A result belongs to the sample of its own conversion, with no pipeline delay.
// - Low-power mode is low-power high with fast low; a start held low then starts at once.
// - Reset high resets the block and aborts any conversion in progress.
// - The result bus is enabled only while chip select and read are both low.
`ifndef SSQ_MAP_SVH
`define SSQ_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSQ_OFF_CTRL       8'h00
`define SSQ_OFF_STATUS     8'h04
`define SSQ_OFF_RESULT     8'h08
`define SSQ_OFF_INT_STATUS 8'h0c
`define SSQ_OFF_INT_CLEAR  8'h10
`define SSQ_OFF_INT_ENABLE 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SSQ_CTRL_ENABLE    0
`define SSQ_CTRL_SOFT      1
`define SSQ_INT_DONE       0
`define SSQ_INT_STALE      1
`define SSQ_INT_IGNORED    2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSQ_CTRL_RST       1'b1
`define SSQ_INT_EN_RST     3'h0
`define SSQ_PIN_RST        7'h61

// ----------------------------------------
// Timing
// ----------------------------------------
`define SSQ_CLK_KHZ        20000
`define SSQ_RATE_FAST_KSPS 1000
`define SSQ_RATE_NORM_KSPS 800
`define SSQ_RATE_LOW_KSPS  666
`define SSQ_GAP_US         1000
`define SSQ_PER_FAST ((`SSQ_CLK_KHZ + `SSQ_RATE_FAST_KSPS - 1) / `SSQ_RATE_FAST_KSPS)
`define SSQ_PER_NORM ((`SSQ_CLK_KHZ + `SSQ_RATE_NORM_KSPS - 1) / `SSQ_RATE_NORM_KSPS)
`define SSQ_PER_LOW  ((`SSQ_CLK_KHZ + `SSQ_RATE_LOW_KSPS - 1) / `SSQ_RATE_LOW_KSPS)
`define SSQ_GAP_CYCLES (`SSQ_GAP_US * `SSQ_CLK_KHZ / 1000)

`endif

// ==== inc/ssq_pkg.sv ====
// Types of the conversion sequencer
package ssq_pkg;
	typedef enum logic [2:0] {
		ST_ACQ,
		ST_OPEN_GND,
		ST_HOLD,
		ST_SAR,
		ST_PDOWN
	} ssq_state_t;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_FAST,
		MODE_LOW_POWER
	} ssq_mode_t;
endpackage

// ==== inc/ssq_sar_if.sv ====
// Link between the sequencer and its approximation engine
`timescale 1ns/1ps
`default_nettype none
interface ssq_sar_if;
	logic        start;
	logic        comp_keep;
	logic        done;
	logic [15:0] trial;
	logic [15:0] code;

	modport ctrl   (output start, output comp_keep,
	                input done, input trial, input code);
	modport engine (input start, input comp_keep,
	                output done, output trial, output code);
endinterface
`default_nettype wire

// ==== core/ssq_sar_engine.sv ====
// Successive approximation engine: 16 trials, top bit first
`timescale 1ns/1ps
`default_nettype none
module ssq_sar_engine (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Sequencer side
	ssq_sar_if.engine sar
);
	logic [3:0]  step;
	logic        running;
	wire  [15:0] bit_mask = 16'h0001 << step;
	wire  [15:0] next_mask = bit_mask >> 1;
	wire  [15:0] decided = sar.comp_keep ? sar.trial
	                                     : (sar.trial & ~bit_mask);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			step    <= 4'hf;
			running <= 1'b0;
			sar.trial <= 16'h0000;
			sar.code  <= 16'h0000;
			sar.done  <= 1'b0;
		end else begin
			sar.done <= 1'b0;
			if (sar.start) begin
				running   <= 1'b1;
				step      <= 4'hf;
				sar.trial <= 16'h8000;
			end else if (running) begin
				sar.trial <= decided | next_mask;
				step      <= step - 4'h1;
				if (step == 4'h0) begin
					running  <= 1'b0;
					sar.code <= decided;
					sar.done <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== core/ssq_sequencer.sv ====
// Conversion sequencer top: pins, mode timing, registers, interrupt
`timescale 1ns/1ps
`default_nettype none
`include "ssq_map.svh"

module ssq_sequencer
	import ssq_pkg::*;
#(
	parameter int unsigned GAP_CYCLES = `SSQ_GAP_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Converter control pins
	input  wire logic        conversion_start_n,
	input  wire logic        coding_select,
	input  wire logic        power_down_input,
	input  wire logic        fast_mode,
	input  wire logic        low_power_mode,
	input  wire logic        chip_select_n,
	input  wire logic        read_n,
	// Analog array control
	input  wire logic        comparator_keep,
	output logic             busy,
	output logic             ground_switch_open,
	output logic             arrays_on_reference,
	output logic      [15:0] dac_trial,
	output logic             power_save,
	// Result bus
	output logic      [15:0] data_out,
	output logic             data_enable,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	// Interrupt
	output logic             irq
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Only the second stage is read; the first may still be settling
	logic [6:0] pin_meta;
	logic [6:0] pin_sync;
	wire  [6:0] pin_raw = {read_n, chip_select_n, low_power_mode,
	                       fast_mode, power_down_input, coding_select,
	                       conversion_start_n};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_meta <= `SSQ_PIN_RST;
			pin_sync <= `SSQ_PIN_RST;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	wire start_low  = ~pin_sync[0];
	wire straight   = pin_sync[1];
	wire pd_req     = pin_sync[2];
	wire fast_pin   = pin_sync[3];
	wire low_pin    = pin_sync[4];
	wire bus_select = ~pin_sync[5] & ~pin_sync[6];

	// ----------------------------------------
	// Mode and throughput limit
	// ----------------------------------------
	ssq_mode_t mode;
	logic [4:0] period_cycles;

	assign mode = fast_pin ? MODE_FAST
	            : (low_pin ? MODE_LOW_POWER : MODE_NORMAL);

	// Periods are whole cycles rounded up, so no mode beats its rate
	always_comb begin
		unique case (mode)
			MODE_FAST:      period_cycles = 5'(`SSQ_PER_FAST);
			MODE_LOW_POWER: period_cycles = 5'(`SSQ_PER_LOW);
			default:        period_cycles = 5'(`SSQ_PER_NORM);
		endcase
	end

	// ----------------------------------------
	// State and counters
	// ----------------------------------------
	ssq_state_t state;
	ssq_state_t next_state;
	logic [4:0]  period_cnt;
	logic [15:0] gap_cnt;
	logic        armed;
	logic        start_prev;
	logic        soft_pending;
	logic        ctrl_enable;
	logic [15:0] result;
	logic        result_stale;
	logic        conv_stale;
	logic [2:0]  int_status;
	logic [2:0]  int_enable;

	// ----------------------------------------
	// Approximation engine
	// ----------------------------------------
	// It loads its first trial in the hold cycle, so the arrays settle first
	ssq_sar_if sar_bus();

	ssq_sar_engine u_engine (
		.clock (clock),
		.rst   (rst),
		.sar   (sar_bus.engine)
	);

	// ----------------------------------------
	// Start qualification
	// ----------------------------------------
	// Acquisition ends when one full period has passed since the last start
	wire acq_done = (period_cnt >= period_cycles - 5'd1);
	// Fast and normal need a fresh fall; low-power also takes a held level
	wire pin_go = start_low & (armed | (mode == MODE_LOW_POWER));
	wire start_ok = (state == ST_ACQ) & acq_done & ctrl_enable & ~pd_req
	              & (pin_go | soft_pending);
	wire start_edge = start_prev & start_low;
	wire ignored_evt = start_edge & (state != ST_ACQ);
	wire gap_long = (gap_cnt >= 16'(GAP_CYCLES));
	wire done_evt = sar_bus.done;
	// Code from the engine is straight binary; two's complement flips the top
	wire [15:0] coded = straight ? sar_bus.code
	                  : {~sar_bus.code[15], sar_bus.code[14:0]};

	assign sar_bus.start = (state == ST_HOLD);
	assign sar_bus.comp_keep = comparator_keep;
	assign dac_trial = sar_bus.trial;

	// ----------------------------------------
	// Sequencing
	// ----------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_ACQ: begin
				if (start_ok)
					next_state = ST_OPEN_GND;
				else if (pd_req)
					next_state = ST_PDOWN;
			end
			ST_OPEN_GND: next_state = ST_HOLD;
			ST_HOLD:     next_state = ST_SAR;
			ST_SAR: begin
				if (done_evt)
					next_state = ST_ACQ;
			end
			ST_PDOWN: begin
				if (!pd_req)
					next_state = ST_ACQ;
			end
			default:     next_state = ST_ACQ;
		endcase
	end

	// ----------------------------------------
	// State register and counters
	// ----------------------------------------
	// Reset is asynchronous, so a conversion in flight is dropped at once
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= ST_ACQ;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			period_cnt <= 5'h1f;
			start_prev <= 1'b0;
			armed      <= 1'b0;
		end else begin
			start_prev <= ~start_low;
			if (start_ok)
				period_cnt <= 5'h00;
			else if (period_cnt != 5'h1f)
				period_cnt <= period_cnt + 5'h01;
			if (start_ok)
				armed <= 1'b0;
			else if (!start_low)
				armed <= 1'b1;
		end
	end

	// Gap counter starts saturated so the first result after reset is stale if it is taken in fast mode
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			gap_cnt    <= 16'hffff;
			conv_stale <= 1'b0;
		end else begin
			if (start_ok) begin
				gap_cnt    <= 16'h0000;
				conv_stale <= gap_long & (mode == MODE_FAST);
			end else if (gap_cnt != 16'hffff) begin
				gap_cnt <= gap_cnt + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Outputs to the analog side
	// ----------------------------------------
	wire next_busy = (next_state == ST_OPEN_GND) | (next_state == ST_HOLD)
	               | (next_state == ST_SAR);
	wire next_hold = (next_state == ST_HOLD) | (next_state == ST_SAR);
	// Low-power mode idles the array once acquisition is over
	wire next_save = (next_state == ST_PDOWN)
	               | ((next_state == ST_ACQ) & (mode == MODE_LOW_POWER)
	                  & acq_done);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy                <= 1'b0;
			ground_switch_open  <= 1'b0;
			arrays_on_reference <= 1'b0;
			power_save          <= 1'b0;
		end else begin
			busy                <= next_busy;
			ground_switch_open  <= next_busy;
			arrays_on_reference <= next_hold;
			power_save          <= next_save;
		end
	end

	// ----------------------------------------
	// Result and read-out bus
	// ----------------------------------------
	// Result is latched on the same edge that drops busy
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			result       <= 16'h0000;
			result_stale <= 1'b0;
			data_out     <= 16'h0000;
		end else begin
			if (done_evt) begin
				result       <= coded;
				result_stale <= conv_stale;
			end
			data_out <= done_evt ? coded : result;
		end
	end

	// The enable follows the synchronised pins, one cycle behind them
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			data_enable <= 1'b0;
		end else begin
			data_enable <= bus_select;
		end
	end

	// ----------------------------------------
	// AHB-Lite register slave
	// ----------------------------------------
	// Writes complete in the data phase, while hwdata stands
	logic       wr_pend;
	logic [7:0] wr_addr;
	wire        addr_phase = hsel & hready & htrans[1];
	wire  [7:0] rd_addr = haddr[7:0];
	wire        wr_now = wr_pend;
	wire        wr_ctrl = wr_now & (wr_addr == `SSQ_OFF_CTRL);
	wire        wr_clear = wr_now & (wr_addr == `SSQ_OFF_INT_CLEAR);
	wire        wr_enable = wr_now & (wr_addr == `SSQ_OFF_INT_ENABLE);
	wire  [2:0] events = {ignored_evt, done_evt & conv_stale, done_evt};
	wire  [2:0] clear_bits = wr_clear ? hwdata[2:0] : 3'h0;
	// A hardware event in the clearing cycle survives the clear
	wire  [2:0] next_int = (int_status & ~clear_bits) | events;
	wire [31:0] status_word = {26'h0, result_stale, mode, pd_req & ~busy,
	                           state == ST_PDOWN, busy};
	wire        sel_ctrl = (rd_addr == `SSQ_OFF_CTRL);
	wire        sel_status = (rd_addr == `SSQ_OFF_STATUS);
	wire        sel_result = (rd_addr == `SSQ_OFF_RESULT);
	wire        sel_int_status = (rd_addr == `SSQ_OFF_INT_STATUS);
	wire        sel_int_enable = (rd_addr == `SSQ_OFF_INT_ENABLE);
	// Unmapped offsets select nothing and read as zero
	wire [31:0] rd_word = ({32{sel_ctrl}} & {31'h0, ctrl_enable})
	                    | ({32{sel_status}} & status_word)
	                    | ({32{sel_result}} & {16'h0, result})
	                    | ({32{sel_int_status}} & {29'h0, int_status})
	                    | ({32{sel_int_enable}} & {29'h0, int_enable});

	// No wait states: read data is registered in the address phase
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= addr_phase & hwrite;
			if (addr_phase)
				wr_addr <= rd_addr;
			if (addr_phase & ~hwrite)
				hrdata <= rd_word;
		end
	end

	// ----------------------------------------
	// Control and interrupt registers
	// ----------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_enable  <= `SSQ_CTRL_RST;
			soft_pending <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_enable <= hwdata[`SSQ_CTRL_ENABLE];
			if (start_ok)
				soft_pending <= 1'b0;
			else if (wr_ctrl & hwdata[`SSQ_CTRL_SOFT])
				soft_pending <= 1'b1;
		end
	end

	// The interrupt follows the next status, so it rises with the event
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			int_enable <= `SSQ_INT_EN_RST;
			int_status <= 3'h0;
			irq        <= 1'b0;
		end else begin
			if (wr_enable)
				int_enable <= hwdata[2:0];
			int_status <= next_int;
			irq        <= |(next_int & int_enable);
		end
	end

endmodule
`default_nettype wire

// ==== testbench/ssq_checker.sv ====
// Assertion checker on the sequencer top ports
`timescale 1ns/1ps
`default_nettype none
module ssq_checker (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst,
	// Pins
	input wire logic        chip_select_n,
	input wire logic        read_n,
	input wire logic        power_down_input,
	input wire logic        coding_select,
	input wire logic        busy,
	input wire logic        ground_switch_open,
	input wire logic        arrays_on_reference,
	input wire logic [15:0] dac_trial,
	input wire logic [15:0] data_out,
	input wire logic        data_enable,
	// Bus
	input wire logic        hreadyout,
	input wire logic        hresp
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// ----------------------------------------
	// Conversion sequence
	// ----------------------------------------
	a_gnd_with_busy: assert property (
		ground_switch_open == busy) else $error("ground switch off busy");
	a_hold_then_msb: assert property (
		$rose(busy) |=> arrays_on_reference ##1 dac_trial == 16'h8000)
		else $error("hold or first trial wrong");
	a_busy_length: assert property (
		$rose(busy) |-> ##18 busy ##1 !busy) else $error("busy length");
	a_release_at_end: assert property (
		$fell(busy) |-> !arrays_on_reference) else $error("arrays held");
	a_code_steady: assert property (
		busy && $past(busy) |-> $stable(data_out))
		else $error("code moved in conversion");
	a_pd_no_start: assert property (
		power_down_input[*5] |-> !$rose(busy)) else $error("start in pd");
	// Sync latency is two flops plus the output register
	a_bus_enabled: assert property (
		(!chip_select_n && !read_n)[*4] |-> data_enable)
		else $error("bus not enabled");
	a_bus_disabled: assert property (
		chip_select_n[*4] |-> !data_enable) else $error("bus enabled");
	a_bus_zero_wait: assert property (
		!$past(rst) |-> hreadyout && !hresp) else $error("bus wait or error");

	c_convert: cover property ($fell(busy));
	c_binary: cover property ($rose(busy) && coding_select);
	c_enable: cover property (data_enable);
endmodule

bind ssq_sequencer ssq_checker i_chk (
	.clock              (clock),
	.rst                (rst),
	.chip_select_n      (chip_select_n),
	.read_n             (read_n),
	.power_down_input   (power_down_input),
	.coding_select      (coding_select),
	.busy               (busy),
	.ground_switch_open (ground_switch_open),
	.arrays_on_reference(arrays_on_reference),
	.dac_trial          (dac_trial),
	.data_out           (data_out),
	.data_enable        (data_enable),
	.hreadyout          (hreadyout),
	.hresp              (hresp)
);
`default_nettype wire

// ==== testbench/ssq_comparator_model.sv ====
// Comparator model: tracks the input, holds it while converting
`timescale 1ns/1ps
`default_nettype none
module ssq_comparator_model (
	// Clock
	input wire logic        clock,
	// Array side
	input wire logic        busy,
	input wire logic [15:0] dac_trial,
	input wire logic [15:0] sample,
	output logic            comparator_keep
);
	logic [15:0] held;

	// Tracks only in acquisition, so later input changes cannot leak in
	always_ff @(posedge clock) begin
		if (!busy)
			held <= sample;
	end
	assign comparator_keep = (held >= dac_trial);
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ssq_map.svh"
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
	num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        start_n = 1'b1;
	logic        coding = 1'b1;
	logic        pd = 1'b0;
	logic        fast = 1'b0;
	logic        lowp = 1'b0;
	logic        cs_n = 1'b1;
	logic        rd_n = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [15:0] sample = 16'h0;
	logic        keep, busy, gnd, onref, psave, den, hrdy, hresp, irq;
	logic [15:0] trial, dout;
	logic [31:0] hrdata, rd;
	int          num_errors = 0;
	int          tests_run = 0;

	ssq_sequencer #(.GAP_CYCLES(50)) i_dut (
		.clock(clock), .rst(rst), .conversion_start_n(start_n),
		.coding_select(coding), .power_down_input(pd), .fast_mode(fast),
		.low_power_mode(lowp), .chip_select_n(cs_n), .read_n(rd_n),
		.comparator_keep(keep), .busy(busy), .ground_switch_open(gnd),
		.arrays_on_reference(onref), .dac_trial(trial), .power_save(psave),
		.data_out(dout), .data_enable(den), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp),
		.irq(irq));
	ssq_comparator_model i_cmp (.clock(clock), .busy(busy),
		.dac_trial(trial), .sample(sample), .comparator_keep(keep));

	initial begin
		forever #25 clock = ~clock;
	end

	task automatic results;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic wbusy(logic v);
		for (int n = 0; n < 100 && busy !== v; n++)
			@(posedge clock);
		if (busy !== v) begin
			`CHK("busy wait", v, busy)
			results;
		end
	endtask
	task automatic ahb(logic w, logic [7:0] a, logic [31:0] d);
		int n = 0;
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clock); while (hrdy !== 1'b1 && ++n < 20);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clock); while (hrdy !== 1'b1 && ++n < 40);
		rd = hrdata;
		`CHK("hready", 1'b1, hrdy)
		if (hrdy !== 1'b1)
			results;
	endtask
	task automatic conv(logic [15:0] s, logic sb);
		sample <= s;
		coding <= sb;
		start_n <= 1'b0;
		wbusy(1'b1);
		// Moving the input now must not reach the code
		sample <= ~s;
		start_n <= 1'b1;
		wbusy(1'b0);
		`CHK("code", sb ? s : s ^ 16'h8000, dout)
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic sc_codes;
		logic [15:0] tab[5] = '{16'h0000, 16'hffff, 16'h7fff, 16'h8000,
			16'h1234};
		foreach (tab[i]) begin
			conv(tab[i], 1'b1);
			conv(tab[i], 1'b0);
		end
	endtask
	task automatic sc_modes;
		int per[3] = '{`SSQ_PER_NORM, `SSQ_PER_FAST, `SSQ_PER_LOW};
		int n;
		for (int m = 0; m < 3; m++) begin
			fast <= (m == 1);
			lowp <= (m == 2);
			cyc(4);
			start_n <= 1'b0;
			wbusy(1'b1);
			start_n <= (m != 2);
			n = 0;
			while (busy === 1'b1 && n < 60) begin
				@(posedge clock);
				n++;
			end
			start_n <= 1'b0;
			while (busy !== 1'b1 && n < 60) begin
				@(posedge clock);
				n++;
			end
			`CHK("spacing", 1'b1, n >= per[m] && n < per[m] + 8)
			if (n >= 60)
				results;
			start_n <= 1'b1;
			wbusy(1'b0);
			cyc(per[m]);
		end
		fast <= 1'b0;
		lowp <= 1'b0;
		cyc(4);
	endtask
	task automatic sc_irq;
		ahb(1'b1, `SSQ_OFF_INT_CLEAR, 32'h7);
		ahb(1'b1, `SSQ_OFF_INT_ENABLE, 32'h5);
		start_n <= 1'b0;
		wbusy(1'b1);
		start_n <= 1'b1;
		cyc(3);
		// A fall while converting is refused and flagged
		start_n <= 1'b0;
		cyc(3);
		start_n <= 1'b1;
		wbusy(1'b0);
		ahb(1'b0, `SSQ_OFF_INT_STATUS, 32'h0);
		`CHK("int status", 3'h5, rd[2:0])
		`CHK("irq", 1'b1, irq)
		ahb(1'b1, `SSQ_OFF_INT_ENABLE, 32'h0);
		cyc(2);
		`CHK("irq masked", 1'b0, irq)
		ahb(1'b1, `SSQ_OFF_INT_CLEAR, 32'h7);
		ahb(1'b1, `SSQ_OFF_INT_ENABLE, 32'h7);
		cyc(2);
		`CHK("irq cleared", 1'b0, irq)
		ahb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rd)
	endtask
	task automatic sc_stale;
		ahb(1'b1, `SSQ_OFF_INT_CLEAR, 32'h7);
		fast <= 1'b1;
		cyc(60);
		// First result after a long gap in fast mode is flagged stale
		conv(16'h4321, 1'b1);
		ahb(1'b0, `SSQ_OFF_INT_STATUS, 32'h0);
		`CHK("stale first", 1'b1, rd[1])
		ahb(1'b0, `SSQ_OFF_STATUS, 32'h0);
		`CHK("stale status", 1'b1, rd[5])
		ahb(1'b1, `SSQ_OFF_INT_CLEAR, 32'h7);
		conv(16'h4321, 1'b1);
		ahb(1'b0, `SSQ_OFF_INT_STATUS, 32'h0);
		`CHK("stale next", 1'b0, rd[1])
		fast <= 1'b0;
		cyc(4);
	endtask
	task automatic sc_pd_reset;
		start_n <= 1'b0;
		wbusy(1'b1);
		pd <= 1'b1;
		start_n <= 1'b1;
		wbusy(1'b0);
		cyc(3);
		start_n <= 1'b0;
		cyc(40);
		`CHK("pd blocks", 1'b0, busy)
		`CHK("pd saves", 1'b1, psave)
		start_n <= 1'b1;
		pd <= 1'b0;
		cyc(4);
		start_n <= 1'b0;
		wbusy(1'b1);
		start_n <= 1'b1;
		cyc(5);
		rst <= 1'b1;
		cyc(2);
		`CHK("abort", 1'b0, busy)
		rst <= 1'b0;
		cyc(4);
	endtask
	task automatic sc_bus;
		cs_n <= 1'b0;
		cyc(5);
		`CHK("bus off", 1'b0, den)
		rd_n <= 1'b0;
		cyc(5);
		`CHK("bus on", 1'b1, den)
		cs_n <= 1'b1;
		cyc(5);
		`CHK("bus off cs", 1'b0, den)
		rd_n <= 1'b1;
	endtask

	initial begin
		cyc(20);
		rst <= 1'b0;
		cyc(4);
		sc_codes;
		sc_modes;
		sc_irq;
		sc_stale;
		sc_pd_reset;
		sc_bus;
		results;
	end
endmodule
`default_nettype wire
